// ### rtl/gsi2c_defs.svh
`ifndef GSI2C_DEFS_SVH
`define GSI2C_DEFS_SVH
// target address and pointer locations
`define GSI2C_TARGET_ADDR 7'h32
`define GSI2C_PTR_RESET 8'h00
`define GSI2C_SCRATCH_FIRST 8'h88
`define GSI2C_SCRATCH_LAST 8'h8b
`define GSI2C_SCRATCH_RESET 8'h00
`define GSI2C_SCRATCH_COUNT 4
// bus rates in kHz and core clock in kHz
`define GSI2C_STD_KHZ 100
`define GSI2C_FAST_KHZ 400
`define GSI2C_CLK_KHZ 25000
// core cycles per fast-mode scl period
`define GSI2C_FAST_CYC (`GSI2C_CLK_KHZ / `GSI2C_FAST_KHZ)
`endif

// ### rtl/gsi2c_pkg.sv
`default_nettype none
package gsi2c_pkg;
	typedef enum logic [6:0] {
		GSI2C_IDLE = 7'h01,
		GSI2C_ADDR = 7'h02,
		GSI2C_AACK = 7'h04,
		GSI2C_WRB = 7'h08,
		GSI2C_WACK = 7'h10,
		GSI2C_RDB = 7'h20,
		GSI2C_RACK = 7'h40
	} gsi2c_state_t;
endpackage
`default_nettype wire

// ### rtl/gsi2c_port.sv
`include "gsi2c_defs.svh"
`default_nettype none
module gsi2c_port import gsi2c_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// i2c pins, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// status
	output logic [7:0] pointer,
	output logic busy
);
	// three-stage input synchronisers
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic scl_reg, sda_reg;
	logic scl_next, sda_next;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			scl_sync_reg <= 3'h7;
			sda_sync_reg <= 3'h7;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
		end
	end

	// filtered levels change when stages two and three agree
	always_comb begin
		scl_next = scl_reg;
		sda_next = sda_reg;
		if (scl_sync_reg[1] == scl_sync_reg[2])
			scl_next = scl_sync_reg[2];
		if (sda_sync_reg[1] == sda_sync_reg[2])
			sda_next = sda_sync_reg[2];
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			scl_reg <= 1'b1;
			sda_reg <= 1'b1;
		end else begin
			scl_reg <= scl_next;
			sda_reg <= sda_next;
		end
	end

	// bus events from filtered levels, 62 cycles per fast scl period
	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_rise = scl_next & ~scl_reg;
	assign scl_fall = ~scl_next & scl_reg;
	assign start_ev = scl_reg & scl_next & sda_reg & ~sda_next;
	assign stop_ev = scl_reg & scl_next & ~sda_reg & sda_next;

	// scratch decode used for read and write
	function automatic logic is_scratch(input logic [7:0] a);
		is_scratch = (a >= `GSI2C_SCRATCH_FIRST) && (a <= `GSI2C_SCRATCH_LAST);
	endfunction

	// register space storage
	logic [7:0] scratch_reg [`GSI2C_SCRATCH_COUNT];
	logic [7:0] scratch_next [`GSI2C_SCRATCH_COUNT];

	// protocol state
	gsi2c_state_t state_reg, state_next;
	logic [7:0] shift_reg, shift_next;
	logic [3:0] bitcnt_reg, bitcnt_next;
	logic [7:0] ptr_reg, ptr_next;
	logic first_reg, first_next;
	logic sda_low_reg, sda_low_next;
	logic nack_reg, nack_next;

	// register read mux
	logic [7:0] rd_data;
	always_comb begin
		rd_data = 8'h00;
		if (is_scratch(ptr_reg))
			rd_data = scratch_reg[ptr_reg[1:0]];
	end

	always_comb begin
		state_next = state_reg;
		shift_next = shift_reg;
		bitcnt_next = bitcnt_reg;
		ptr_next = ptr_reg;
		first_next = first_reg;
		sda_low_next = sda_low_reg;
		nack_next = nack_reg;
		for (int i = 0; i < `GSI2C_SCRATCH_COUNT; i++)
			scratch_next[i] = scratch_reg[i];
		if (start_ev) begin
			state_next = GSI2C_ADDR;
			bitcnt_next = 4'h0;
			sda_low_next = 1'b0;
		end else if (stop_ev) begin
			state_next = GSI2C_IDLE;
			sda_low_next = 1'b0;
		end else begin
			case (state_reg)
				GSI2C_IDLE: begin
					sda_low_next = 1'b0;
				end
				GSI2C_ADDR: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_reg};
						bitcnt_next = bitcnt_reg + 4'h1;
					end else if (scl_fall && bitcnt_reg == 4'h8) begin
						if (shift_reg[7:1] == `GSI2C_TARGET_ADDR) begin
							state_next = GSI2C_AACK;
							sda_low_next = 1'b1;
							first_next = 1'b1;
						end else begin
							state_next = GSI2C_IDLE;
						end
					end
				end
				GSI2C_AACK: begin
					if (scl_fall) begin
						bitcnt_next = 4'h0;
						if (shift_reg[0]) begin
							// read starts wherever the pointer stands
							state_next = GSI2C_RDB;
							shift_next = rd_data;
							sda_low_next = ~rd_data[7];
						end else begin
							state_next = GSI2C_WRB;
							sda_low_next = 1'b0;
						end
					end
				end
				GSI2C_WRB: begin
					if (scl_rise) begin
						shift_next = {shift_reg[6:0], sda_reg};
						bitcnt_next = bitcnt_reg + 4'h1;
					end else if (scl_fall && bitcnt_reg == 4'h8) begin
						state_next = GSI2C_WACK;
						sda_low_next = 1'b1;
						if (first_reg) begin
							ptr_next = shift_reg;
							first_next = 1'b0;
						end else begin
							if (is_scratch(ptr_reg))
								scratch_next[ptr_reg[1:0]] = shift_reg;
							ptr_next = ptr_reg + 8'h01;
						end
					end
				end
				GSI2C_WACK: begin
					if (scl_fall) begin
						state_next = GSI2C_WRB;
						bitcnt_next = 4'h0;
						sda_low_next = 1'b0;
					end
				end
				GSI2C_RDB: begin
					if (scl_rise) begin
						bitcnt_next = bitcnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (bitcnt_reg == 4'h8) begin
							state_next = GSI2C_RACK;
							sda_low_next = 1'b0;
							ptr_next = ptr_reg + 8'h01;
						end else begin
							shift_next = {shift_reg[6:0], 1'b0};
							sda_low_next = ~shift_reg[6];
						end
					end
				end
				GSI2C_RACK: begin
					if (scl_rise) begin
						nack_next = sda_reg;
					end else if (scl_fall) begin
						bitcnt_next = 4'h0;
						if (nack_reg) begin
							state_next = GSI2C_IDLE;
						end else begin
							state_next = GSI2C_RDB;
							shift_next = rd_data;
							sda_low_next = ~rd_data[7];
						end
					end
				end
				default: begin
					state_next = GSI2C_IDLE;
					sda_low_next = 1'b0;
				end
			endcase
		end
	end

	// protocol registers
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state_reg <= GSI2C_IDLE;
			shift_reg <= 8'h00;
			bitcnt_reg <= 4'h0;
			ptr_reg <= `GSI2C_PTR_RESET;
			first_reg <= 1'b0;
			sda_low_reg <= 1'b0;
			nack_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			shift_reg <= shift_next;
			bitcnt_reg <= bitcnt_next;
			ptr_reg <= ptr_next;
			first_reg <= first_next;
			sda_low_reg <= sda_low_next;
			nack_reg <= nack_next;
		end
	end

	// scratch bytes, one register each
	for (genvar g = 0; g < `GSI2C_SCRATCH_COUNT; g++) begin : g_scr
		always_ff @(posedge clock or negedge resetn) begin
			if (!resetn)
				scratch_reg[g] <= `GSI2C_SCRATCH_RESET;
			else
				scratch_reg[g] <= scratch_next[g];
		end
	end

	// open-drain drive; scl is never stretched
	assign scl_out = 1'b0;
	assign scl_oe = 1'b0;
	assign sda_out = 1'b0;
	assign sda_oe = sda_low_reg;
	assign pointer = ptr_reg;
	assign busy = (state_reg != GSI2C_IDLE);
endmodule
`default_nettype wire

// ### verif/gsi2c_host.sv
`default_nettype none
module gsi2c_host (
	// clock and wire level
	input wire logic clock,
	input wire logic sda,
	// driven levels, 1 releases
	output logic scl_o,
	output logic sda_o,
	// last byte and ack bit seen
	output logic [8:0] rx,
	output logic rx_v
);
	timeunit 1ns;
	timeprecision 1ns;
	// bus idle
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
		rx_v = 1'b0;
	end
	// high phase of a 320 ns scl period, three core clocks
	task automatic hw;
		repeat (3) @(posedge clock);
	endtask
	// start or repeated start; scl stays high past the sda fall
	// so the target has seen the start before scl drops
	task automatic start;
		repeat (2) @(posedge clock);
		sda_o <= 1'b1;
		repeat (4) @(posedge clock);
		scl_o <= 1'b1;
		repeat (4) @(posedge clock);
		sda_o <= 1'b0;
		repeat (6) @(posedge clock);
		scl_o <= 1'b0;
	endtask
	task automatic stop;
		repeat (2) @(posedge clock);
		sda_o <= 1'b0;
		repeat (4) @(posedge clock);
		scl_o <= 1'b1;
		repeat (4) @(posedge clock);
		sda_o <= 1'b1;
		repeat (4) @(posedge clock);
	endtask
	// eight bits msb first, then ack slot; low five clocks, high three,
	// since the target moves sda four clocks after each scl fall
	task automatic xfer(input logic [7:0] d, input logic a);
		logic [8:0] r;
		for (int i = 8; i >= 0; i--) begin
			repeat (2) @(posedge clock);
			sda_o <= (i > 0) ? d[i-1] : a;
			repeat (3) @(posedge clock);
			scl_o <= 1'b1;
			hw;
			r[i] = sda;
			scl_o <= 1'b0;
		end
		rx <= r;
		rx_v <= 1'b1;
		@(posedge clock);
		rx_v <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verif/gsi2c_port_monitor.sv
`default_nettype none
module gsi2c_port_monitor (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// pins
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	// status
	input wire logic [7:0] pointer,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	property p_ns; !scl_oe; endproperty
	a_ns: assert property (p_ns) else $error("scl held");
	// open drain: the pins are only ever pulled low
	property p_od; !scl_out && !sda_out; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_qt; !busy |-> !sda_oe; endproperty
	a_qt: assert property (p_qt) else $error("sda idle drive");
	property p_st; $rose(busy) |-> scl_in; endproperty
	a_st: assert property (p_st) else $error("busy no start");
	property p_hd; !busy |=> $stable(pointer); endproperty
	a_hd: assert property (p_hd) else $error("pointer moved");
	property p_ae; $rose(sda_oe) |-> ##[1:1000] !sda_oe; endproperty
	a_ae: assert property (p_ae) else $error("sda stuck");
	property p_sl; $changed(sda_oe) |-> !scl_in; endproperty
	a_sl: assert property (p_sl) else $error("sda moved high");
	// next drive comes no sooner than one eight-clock bit later
	property p_gp; $fell(sda_oe) |=> !sda_oe [*7]; endproperty
	a_gp: assert property (p_gp) else $error("sda glitch");
	property p_rs; $rose(resetn) |-> pointer == 8'h00 && !busy; endproperty
	a_rs: assert property (p_rs) else $error("bad reset");
	// main scenarios
	cover property ($past(pointer) == 8'hff && pointer == 8'h00);
	cover property ($rose(sda_oe));
	cover property ($fell(busy));
endmodule
`default_nettype wire

// ### verif/gsi2c_port_tb.sv
`default_nettype none
module gsi2c_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic scl_out, scl_oe, sda_out, sda_oe, busy, h_scl, h_sda, rx_v;
	logic [7:0] pointer;
	logic [8:0] rx;
	logic [7:0] sd [4];
	logic [8:0] exp_q [$];
	int failures = 0;
	int checks = 0;
	int cyc = 0;
	// open-drain wires with pull-ups
	wire scl = h_scl & ~(scl_oe & ~scl_out);
	wire sda = h_sda & ~(sda_oe & ~sda_out);
	initial begin
		forever #20 clock = ~clock;
	end
	gsi2c_port gsi2c_port_inst (.clock(clock), .resetn(resetn), .scl_in(scl),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .pointer(pointer), .busy(busy));
	gsi2c_host gsi2c_host_inst (.clock(clock), .sda(sda), .scl_o(h_scl), .sda_o(h_sda),
		.rx(rx), .rx_v(rx_v));
	task automatic check(input logic [8:0] s, input logic [8:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("mismatch %0t got %h want %h", $time, s, e);
		end
	endtask
	task automatic stop_test;
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one byte with the expected wire byte and ack
	task automatic bx(input logic [7:0] d, input logic a, input logic [8:0] e);
		exp_q.push_back(e);
		gsi2c_host_inst.xfer(d, a);
	endtask
	// address for write, then pointer byte
	task automatic sel(input logic [7:0] p);
		gsi2c_host_inst.start;
		bx(8'h64, 1'b1, 9'h0c8);
		bx(p, 1'b1, {p, 1'b0});
	endtask
	// each wire byte against the oldest note
	always @(posedge clock) begin
		if (rx_v === 1'b1)
			check(rx, exp_q.pop_front());
	end
	always @(posedge clock) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			stop_test;
		end
	end
	initial begin
		void'($urandom(98350));
		foreach (sd[i]) sd[i] = 8'($urandom);
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		repeat (5) @(posedge clock);
		// foreign address is ignored
		gsi2c_host_inst.start;
		bx(8'h66, 1'b1, 9'h0cd);
		gsi2c_host_inst.stop;
		check(pointer, 8'h00);
		// scratch burst
		sel(8'h88);
		foreach (sd[i]) bx(sd[i], 1'b1, {sd[i], 1'b0});
		gsi2c_host_inst.stop;
		check(pointer, 8'h8c);
		// pointer write and stop, then a read of all four bytes, last one nacked
		sel(8'h88);
		gsi2c_host_inst.stop;
		gsi2c_host_inst.start;
		bx(8'h65, 1'b1, 9'h0ca);
		foreach (sd[i]) bx(8'hff, 1'(i == 3), {sd[i], 1'(i == 3)});
		gsi2c_host_inst.stop;
		check(pointer, 8'h8c);
		// top of the space
		sel(8'hff);
		bx(8'h5a, 1'b1, 9'h0b4);
		gsi2c_host_inst.stop;
		check(pointer, 8'h00);
		// power cycle clears scratch
		resetn <= 1'b0;
		repeat (2) @(posedge clock);
		resetn <= 1'b1;
		repeat (5) @(posedge clock);
		sel(8'h88);
		gsi2c_host_inst.start;
		bx(8'h65, 1'b1, 9'h0ca);
		bx(8'hff, 1'b1, 9'h001);
		gsi2c_host_inst.stop;
		repeat (4) @(posedge clock);
		stop_test;
	end
endmodule
bind gsi2c_port gsi2c_port_monitor gsi2c_port_monitor_inst (.clock(clock),
	.resetn(resetn), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
	.sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .pointer(pointer), .busy(busy));
`default_nettype wire
